// ---- shared/ccs_defs.svh ----
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// register indices as carried in the command address slot
`define CCS_IDX_GP 7'h20
`define CCS_IDX_INTPG 7'h24
`define CCS_IDX_PWR 7'h26
`define CCS_IDX_EXTID 7'h28
`define CCS_IDX_EXTSC 7'h2A
`define CCS_IDX_WIN_LO 7'h60
`define CCS_IDX_WIN_HI 7'h6F

// general-purpose register fields
`define CCS_GP_DOUBLE_RATE_SLOT_SEL_LSB 10
`define CCS_GP_MIX 9
`define CCS_GP_MS 8
`define CCS_GP_LOOPBACK_CTRL 7
`define CCS_GP_RST 16'h0000

// interrupt and paging fields
`define CCS_INT_STAT 15
`define CCS_INT_PIN 14
`define CCS_INT_SENSE 13
`define CCS_INT_CYCLE 12
`define CCS_INT_EN 11
`define CCS_PAGE_VENDOR 4'h0
`define CCS_PAGE_EXT 4'h1
`define CCS_PAGE_LAST 4'h1

// power-down fields
`define CCS_PWR_EXT_AMP_SHUTDOWN 15
`define CCS_PWR_PR_LSB 8
`define CCS_PWR_PR_RST 7'h00

// extended capability: fixed bits, slot-mapping field
`define CCS_EXTID_FIXED 16'h0BC7
`define CCS_EXTID_DSA_LSB 4
`define CCS_DSA_MAP0 24'h347869
`define CCS_DSA_MAP1 24'h7869AB
`define CCS_DSA_MAP2 24'h69AB34
`define CCS_DSA_MAP3 24'hAB3478

// extended status/control fields
`define CCS_ESC_PRK 13
`define CCS_ESC_PRJ 12
`define CCS_ESC_PRI 11
`define CCS_ESC_SPDIF_CONFIG_VALID 10
`define CCS_ESC_LFE_DAC_FLAG 8
`define CCS_ESC_SURROUND_DAC_FLAG 7
`define CCS_ESC_CENTER_DAC_FLAG 6
`define CCS_ESC_SPDIF_SLOT_ASSIGN_LSB 4
`define CCS_ESC_SPDIF 2
`define CCS_ESC_DRA 1
`define CCS_ESC_VRA 0

// frame layout: last bit of slots 0 to 2, first bit of slot 12
`define CCS_SLOT0_END 8'd15
`define CCS_SLOT1_END 8'd35
`define CCS_SLOT2_END 8'd55
`define CCS_SLOT12_BEG 8'd236
`define CCS_GPI_IRQ_BIT 0

`endif

// ---- shared/ccs_pkg.sv ----
package ccs_pkg;

  // general-purpose controls
  typedef struct packed {
    logic loopback_ctrl;
    logic mic_channel_swap;
    logic mono_out_sel;
    logic [1:0] double_rate_slot_sel;
  } ccs_gp_t;

  // power controls seen by the analog sections
  typedef struct packed {
    logic adc_powerdown;
    logic dac_powerdown;
    logic eq_powerdown;
    logic mixer_powerdown;
    logic reference_main_off;
    logic reference_pins_off;
    logic link_powerdown;
    logic internal_clock_off;
    logic headphone_amp_powerdown;
    logic center_dac_powerdown;
    logic surround_dac_powerdown;
    logic lfe_dac_powerdown;
  } ccs_pwr_t;

  // link slot numbers for each dac channel
  typedef struct packed {
    logic [3:0] front_l;
    logic [3:0] front_r;
    logic [3:0] surround_l;
    logic [3:0] surround_r;
    logic [3:0] clfe_l;
    logic [3:0] clfe_r;
  } ccs_slot_map_t;

  // extended audio controls
  typedef struct packed {
    logic variable_rate_enable;
    logic rate_force_48k;
    logic double_rate_enable;
    logic spdif_enable;
    logic [1:0] spdif_slot_assign;
  } ccs_ext_t;

  // subsection ready flags
  typedef struct packed {
    logic reference;
    logic analog;
    logic front_dac;
    logic adc;
  } ccs_ready_t;

endpackage : ccs_pkg

// ---- logic/ccs_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module ccs_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // link pins
  input wire logic bit_clk,
  input wire logic link_sync,
  input wire logic sdata_out,
  output logic sdata_in,
  // on-chip status inputs
  input wire ccs_pkg::ccs_ready_t ready_in,
  input wire logic sense_done,
  input wire logic sense_info,
  input wire logic pin_change,
  input wire logic spdif_cfg_valid,
  // controls to the analog and data path
  output ccs_pkg::ccs_gp_t gp_ctrl,
  output logic [3:0] page_selector,
  output ccs_pkg::ccs_pwr_t pwr_ctrl,
  output logic ext_amp_shutdown,
  output ccs_pkg::ccs_slot_map_t dac_slot_map,
  output ccs_pkg::ccs_ext_t ext_ctrl,
  output logic sense_start,
  output logic sense_abort
);

  // synchronisers for the link pins
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic bclk_d_q; // previous synchronised bit clock
  logic sync_d_q; // sync seen at previous falling edge
  logic [7:0] pos_q; // index of the next bit in the frame
  logic [19:0] rx_q; // incoming shift register
  logic [2:0] tag_q; // frame, slot 1, slot 2 valid
  logic [19:0] cmd_q; // command address slot
  logic cmd_wr_q; // one-cycle write request
  logic cmd_rd_q; // one-cycle read request
  logic [6:0] cmd_idx_q;
  logic [15:0] cmd_data_q;
  logic rsp_pend_q; // read answer waits for next frame
  logic tx_act_q; // answer goes out in this frame
  logic [6:0] rsp_idx_q;
  logic [15:0] rsp_data_q;
  logic sdata_in_q;
  // register state
  logic [15:0] gp_q;
  logic [3:0] page_q;
  logic irq_en_q;
  logic sense_busy_q;
  logic sense_cause_q;
  logic pin_cause_q;
  logic irq_stat_q;
  logic [6:0] pr_q;
  logic ext_amp_shutdown_q;
  logic [1:0] dsa_q;
  logic [2:0] dac_pd_q; // lfe, surround, center
  logic [1:0] spdif_slot_assign_q;
  logic spdif_q;
  logic dra_q;
  logic vra_q;
  logic sense_start_q;
  logic sense_abort_q;
  ccs_pkg::ccs_pwr_t pwr_q;
  ccs_pkg::ccs_slot_map_t map_q;
  ccs_pkg::ccs_ext_t ext_q;
  ccs_pkg::ccs_gp_t gpo_q;
  logic [15:0] rdata; // read mux result
  logic [15:0] int_word;
  logic bclk_s, sync_s, sdo_s, fall, rise, fstart;
  logic [7:0] cur;
  logic [19:0] rx_next;
  logic wr_int, wr_pwr, wr_esc;
  logic ev_sense, ev_pin, clr_irq;

  assign bclk_s = pin_s2_q[0];
  assign sync_s = pin_s2_q[1];
  assign sdo_s = pin_s2_q[2];
  assign fall = bclk_d_q && !bclk_s;
  assign rise = !bclk_d_q && bclk_s;
  assign fstart = sync_s && !sync_d_q;
  assign cur = fstart ? 8'd0 : pos_q; // bit sampled at this edge
  assign rx_next = {rx_q[18:0], sdo_s};

  // two flip-flops per pin; first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      bclk_d_q <= 1'b0;
    end else begin
      pin_s1_q <= {sdata_out, link_sync, bit_clk};
      pin_s2_q <= pin_s1_q;
      bclk_d_q <= bclk_s;
    end
  end

  // controller data is taken at the bit clock's falling edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_d_q <= 1'b0;
      pos_q <= 8'h00;
      rx_q <= 20'h00000;
      tag_q <= 3'h0;
      cmd_q <= 20'h00000;
      cmd_wr_q <= 1'b0;
      cmd_rd_q <= 1'b0;
      cmd_idx_q <= 7'h00;
      cmd_data_q <= 16'h0000;
    end else begin
      cmd_wr_q <= 1'b0;
      cmd_rd_q <= 1'b0;
      if (fall) begin
        sync_d_q <= sync_s;
        pos_q <= cur + 8'd1; // wraps to 0 after bit 255
        rx_q <= rx_next;
        if (cur == `CCS_SLOT0_END) begin
          tag_q <= rx_next[15:13];
        end
        if (cur == `CCS_SLOT1_END) begin
          cmd_q <= rx_next;
        end
        if (cur == `CCS_SLOT2_END && tag_q[2] && tag_q[1]) begin
          cmd_idx_q <= cmd_q[18:12];
          cmd_data_q <= rx_next[19:4];
          cmd_rd_q <= cmd_q[19];
          cmd_wr_q <= !cmd_q[19] && tag_q[0];
        end
      end
    end
  end

  // one bit of the outgoing frame: tag, status slots, slot 12
  function automatic logic tx_bit(input logic [7:0] p, input logic act,
                                  input logic [6:0] idx,
                                  input logic [15:0] dat,
                                  input logic irq);
    logic [15:0] tag;
    logic [19:0] s1;
    logic [19:0] s2;
    logic [19:0] s12;
    logic [7:0] off;
    tag = {1'b1, act, act, 9'h000, 1'b1, 3'h0};
    s1 = {1'b0, idx, 12'h000};
    s2 = {dat, 4'h0};
    s12 = 20'h00000;
    s12[`CCS_GPI_IRQ_BIT] = irq;
    tx_bit = 1'b0;
    if (p <= `CCS_SLOT0_END) begin
      off = `CCS_SLOT0_END - p;
      tx_bit = tag[off[3:0]];
    end else if (p <= `CCS_SLOT1_END) begin
      off = `CCS_SLOT1_END - p;
      tx_bit = s1[off[4:0]];
    end else if (p <= `CCS_SLOT2_END) begin
      off = `CCS_SLOT2_END - p;
      tx_bit = s2[off[4:0]];
    end else if (p >= `CCS_SLOT12_BEG) begin
      off = 8'd255 - p;
      tx_bit = s12[off[4:0]];
    end
  endfunction : tx_bit

  // codec data changes at the rising edge; a read answer rides
  // the frame after the one that carried the request
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsp_pend_q <= 1'b0;
      tx_act_q <= 1'b0;
      rsp_idx_q <= 7'h00;
      rsp_data_q <= 16'h0000;
      sdata_in_q <= 1'b0;
    end else begin
      if (rise) begin
        // interrupt reaches slot 12 only while enabled
        sdata_in_q <= tx_bit(pos_q, (pos_q == 8'd0) ? rsp_pend_q : tx_act_q,
                             rsp_idx_q, rsp_data_q, irq_en_q && irq_stat_q);
        if (pos_q == 8'd0) begin
          tx_act_q <= rsp_pend_q;
        end else if (pos_q == `CCS_SLOT2_END && tx_act_q) begin
          tx_act_q <= 1'b0;
        end
      end
      if (cmd_rd_q) begin
        rsp_pend_q <= 1'b1;
        rsp_idx_q <= cmd_idx_q;
        rsp_data_q <= rdata;
      end else if (rise && pos_q == `CCS_SLOT2_END && tx_act_q) begin
        rsp_pend_q <= 1'b0;
      end
    end
  end

  assign wr_int = cmd_wr_q && cmd_idx_q == `CCS_IDX_INTPG;
  assign wr_pwr = cmd_wr_q && cmd_idx_q == `CCS_IDX_PWR;
  assign wr_esc = cmd_wr_q && cmd_idx_q == `CCS_IDX_EXTSC;

  // general-purpose register, only bits 11..7 stored
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gp_q <= `CCS_GP_RST;
    end else if (cmd_wr_q && cmd_idx_q == `CCS_IDX_GP) begin
      gp_q <= cmd_data_q & 16'h0F80; // reserved bits stay 0
    end
  end

  // page selector and interrupt enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      page_q <= `CCS_PAGE_VENDOR;
      irq_en_q <= 1'b0; // masked out of reset
    end else if (wr_int) begin
      irq_en_q <= cmd_data_q[`CCS_INT_EN];
      // only pages 0..last exist; others fall back to 0 so the
      // read-back differs from what was written
      if (cmd_data_q[3:0] <= `CCS_PAGE_LAST) begin
        page_q <= cmd_data_q[3:0];
      end else begin
        page_q <= `CCS_PAGE_VENDOR;
      end
    end
  end

  // sense cycle: write 1 starts, write 0 aborts a running one
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sense_busy_q <= 1'b0;
      sense_start_q <= 1'b0;
      sense_abort_q <= 1'b0;
    end else begin
      sense_start_q <= wr_int && cmd_data_q[`CCS_INT_CYCLE];
      sense_abort_q <= wr_int && !cmd_data_q[`CCS_INT_CYCLE]
                       && sense_busy_q;
      if (wr_int) begin
        sense_busy_q <= cmd_data_q[`CCS_INT_CYCLE];
      end else if (sense_done) begin
        sense_busy_q <= 1'b0;
      end
    end
  end

  assign ev_sense = (sense_done && sense_busy_q) || sense_info;
  assign ev_pin = pin_change;
  assign clr_irq = wr_int && cmd_data_q[`CCS_INT_STAT];

  // status and causes: a new event beats a same-cycle clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq_stat_q <= 1'b0;
      sense_cause_q <= 1'b0;
      pin_cause_q <= 1'b0;
    end else begin
      // status sets whatever the enable says
      irq_stat_q <= ev_sense || ev_pin || (irq_stat_q && !clr_irq);
      sense_cause_q <= ev_sense || (sense_cause_q && !clr_irq);
      pin_cause_q <= ev_pin || (pin_cause_q && !clr_irq);
    end
  end

  // power-down bits and amplifier pin; ready flags not stored
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pr_q <= `CCS_PWR_PR_RST;
      ext_amp_shutdown_q <= 1'b0; // amplifier enabled out of reset
    end else if (wr_pwr) begin
      pr_q <= cmd_data_q[`CCS_PWR_PR_LSB +: 7];
      ext_amp_shutdown_q <= cmd_data_q[`CCS_PWR_EXT_AMP_SHUTDOWN];
    end
  end

  // slot mapping code of the capability register
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dsa_q <= 2'h0;
    end else if (cmd_wr_q && cmd_idx_q == `CCS_IDX_EXTID) begin
      dsa_q <= cmd_data_q[`CCS_EXTID_DSA_LSB +: 2];
    end
  end

  // extended status/control writable bits
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dac_pd_q <= 3'h0;
      spdif_slot_assign_q <= 2'h0;
      spdif_q <= 1'b0;
      dra_q <= 1'b0;
      vra_q <= 1'b0;
    end else if (wr_esc) begin
      dac_pd_q <= cmd_data_q[`CCS_ESC_PRI +: 3];
      spdif_slot_assign_q <= cmd_data_q[`CCS_ESC_SPDIF_SLOT_ASSIGN_LSB +: 2];
      spdif_q <= cmd_data_q[`CCS_ESC_SPDIF];
      dra_q <= cmd_data_q[`CCS_ESC_DRA];
      vra_q <= cmd_data_q[`CCS_ESC_VRA];
    end
  end

  assign int_word = {irq_stat_q, pin_cause_q, sense_cause_q, sense_busy_q,
                     irq_en_q, 7'h00, page_q};

  // read mux; unmapped indices and the paged window read 0
  always_comb begin
    rdata = 16'h0000;
    unique case (cmd_idx_q)
      `CCS_IDX_GP: rdata = gp_q;
      `CCS_IDX_INTPG: rdata = int_word;
      `CCS_IDX_PWR: rdata = {ext_amp_shutdown_q, pr_q, 4'h0, ready_in};
      `CCS_IDX_EXTID: begin
        rdata = `CCS_EXTID_FIXED;
        rdata[`CCS_EXTID_DSA_LSB +: 2] = dsa_q;
      end
      `CCS_IDX_EXTSC: begin
        rdata = {2'h0, dac_pd_q, spdif_cfg_valid, 1'b0, ~dac_pd_q,
                 spdif_slot_assign_q, 1'b0, spdif_q, dra_q, vra_q};
      end
      default: rdata = 16'h0000;
    endcase
  end

  // power controls derived from the stored bits
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwr_q <= '0;
    end else begin
      pwr_q.adc_powerdown <= pr_q[0];
      pwr_q.dac_powerdown <= pr_q[1];
      pwr_q.eq_powerdown <= pr_q[1];
      pwr_q.mixer_powerdown <= pr_q[2];
      // main reference stays up while the adc (PR0) or dac (PR1) runs
      pwr_q.reference_main_off <= pr_q[3] && pr_q[0] && pr_q[1];
      pwr_q.reference_pins_off <= pr_q[3];
      pwr_q.link_powerdown <= pr_q[4];
      // clock stop waits for every converter and the link
      pwr_q.internal_clock_off <= pr_q[5] && pr_q[0] && pr_q[1]
                                  && pr_q[4] && (&dac_pd_q);
      pwr_q.headphone_amp_powerdown <= pr_q[6];
      pwr_q.center_dac_powerdown <= dac_pd_q[0];
      pwr_q.surround_dac_powerdown <= dac_pd_q[1];
      pwr_q.lfe_dac_powerdown <= dac_pd_q[2];
    end
  end

  // dac slot placement and extended controls
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      map_q <= `CCS_DSA_MAP0;
      ext_q <= '0;
      gpo_q <= '0;
    end else begin
      unique case (dsa_q)
        2'h0: map_q <= `CCS_DSA_MAP0;
        2'h1: map_q <= `CCS_DSA_MAP1;
        2'h2: map_q <= `CCS_DSA_MAP2;
        2'h3: map_q <= `CCS_DSA_MAP3;
      endcase
      ext_q.variable_rate_enable <= vra_q;
      ext_q.rate_force_48k <= !vra_q;
      ext_q.double_rate_enable <= dra_q;
      ext_q.spdif_enable <= spdif_q;
      ext_q.spdif_slot_assign <= spdif_slot_assign_q;
      gpo_q.loopback_ctrl <= gp_q[`CCS_GP_LOOPBACK_CTRL];
      gpo_q.mic_channel_swap <= gp_q[`CCS_GP_MS];
      gpo_q.mono_out_sel <= gp_q[`CCS_GP_MIX];
      gpo_q.double_rate_slot_sel <= gp_q[`CCS_GP_DOUBLE_RATE_SLOT_SEL_LSB +: 2];
    end
  end

  assign sdata_in = sdata_in_q;
  assign gp_ctrl = gpo_q;
  assign page_selector = page_q;
  assign pwr_ctrl = pwr_q;
  assign ext_amp_shutdown = ext_amp_shutdown_q;
  assign dac_slot_map = map_q;
  assign ext_ctrl = ext_q;
  assign sense_start = sense_start_q;
  assign sense_abort = sense_abort_q;

  // checks beside the logic
  irq_has_cause_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    irq_stat_q |-> (sense_cause_q || pin_cause_q))
    else $error("interrupt status without a cause");
  irq_clear_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (clr_irq && !ev_sense && !ev_pin) |=>
      (!irq_stat_q && !sense_cause_q && !pin_cause_q))
    else $error("clear left status or cause set");
  irq_w0_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_int && !cmd_data_q[`CCS_INT_STAT] && irq_stat_q) |=> irq_stat_q)
    else $error("writing 0 changed interrupt status");
  page_absent_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_int && cmd_data_q[3:0] > `CCS_PAGE_LAST) |=>
      (page_q != $past(cmd_data_q[3:0])))
    else $error("absent page reads back as written");
  irq_en_rst_a: assert property (@(posedge clk_sys)
    $rose(rstn) |-> !irq_en_q)
    else $error("interrupt enable not masked after reset");
  sense_run_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_int && cmd_data_q[`CCS_INT_CYCLE]) |=> (sense_busy_q && sense_start_q))
    else $error("sense cycle did not start");
  ref_kept_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pr_q[3] && !pr_q[0]) |=> (!pwr_q.reference_main_off
      && pwr_q.reference_pins_off))
    else $error("reference stopped while adc powered");
  clk_gate_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    pwr_q.internal_clock_off |-> $past(pr_q[4] && pr_q[0] && pr_q[1]))
    else $error("clock stopped with blocks powered");
  amp_pin_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_pwr |=> (ext_amp_shutdown == $past(cmd_data_q[`CCS_PWR_EXT_AMP_SHUTDOWN])))
    else $error("amplifier pin does not follow write");
  rate_48k_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (wr_esc && !cmd_data_q[`CCS_ESC_VRA]) |=> ##1 ext_ctrl.rate_force_48k)
    else $error("rates not forced to 48 kHz");

endmodule : ccs_regs

`default_nettype wire

// ---- tb/ccs_link_ctl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// behavioural link controller: shifts one 256-bit frame per call
module ccs_link_ctl_model (
  // link pins
  output logic bit_clk,
  output logic link_sync,
  output logic sdata_out,
  input wire logic sdata_in
);
  // clock stands still low between frames
  initial begin
    bit_clk = 1'b0;
    link_sync = 1'b0;
    sdata_out = 1'b0;
  end

  // launch on rise, capture on fall; rx[i] is frame bit i
  task automatic frame(input logic [0:255] tx, output logic [0:255] rx);
    for (int i = 0; i < 256; i++) begin
      #32 bit_clk = 1'b1;
      link_sync = (i < 16);
      sdata_out = tx[i];
      #32 bit_clk = 1'b0;
      rx[i] = sdata_in;
    end
    // released line shows the inverse, so a stale value never passes
    #32 sdata_out = ~sdata_out;
    #64 link_sync = 1'b0;
  endtask : frame
endmodule : ccs_link_ctl_model
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  // clock, reset and on-chip status drive
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic sense_done = 1'b0;
  logic sense_info = 1'b0;
  logic pin_change = 1'b0;
  logic spdif_cfg_valid = 1'b0;
  ccs_pkg::ccs_ready_t ready_in = 4'h0;
  // link wires
  wire logic bit_clk, link_sync, sdata_out, sdata_in;
  // design outputs
  ccs_pkg::ccs_gp_t gp_ctrl;
  logic [3:0] page_selector;
  ccs_pkg::ccs_pwr_t pwr_ctrl;
  logic ext_amp_shutdown;
  ccs_pkg::ccs_slot_map_t dac_slot_map;
  ccs_pkg::ccs_ext_t ext_ctrl;
  logic sense_start, sense_abort;
  // bookkeeping; a read is checked in the frame after it
  int err_total = 0;
  int comparisons = 0;
  int n_st = 0;
  int n_ab = 0;
  logic [0:255] last_rx;
  logic pend = 1'b0;
  logic [6:0] pidx;
  logic [15:0] pexp, d;

  always #2.5 clk_sys = ~clk_sys;

  ccs_regs ccs_regs_inst (.clk_sys(clk_sys), .rstn(rstn),
    .bit_clk(bit_clk), .link_sync(link_sync), .sdata_out(sdata_out),
    .sdata_in(sdata_in), .ready_in(ready_in), .sense_done(sense_done),
    .sense_info(sense_info), .pin_change(pin_change),
    .spdif_cfg_valid(spdif_cfg_valid), .gp_ctrl(gp_ctrl),
    .page_selector(page_selector), .pwr_ctrl(pwr_ctrl),
    .ext_amp_shutdown(ext_amp_shutdown), .dac_slot_map(dac_slot_map),
    .ext_ctrl(ext_ctrl), .sense_start(sense_start),
    .sense_abort(sense_abort));

  ccs_link_ctl_model ccs_link_ctl_model_inst (.bit_clk(bit_clk),
    .link_sync(link_sync), .sdata_out(sdata_out), .sdata_in(sdata_in));

  // count one-cycle sense pulses so no pulse is missed
  always @(posedge clk_sys) begin
    if (sense_start === 1'b1) n_st++;
    if (sense_abort === 1'b1) n_ab++;
  end

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t read got %h exp %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t output got %h exp %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic stop_test;
    if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // one command frame; for a read, dat is the expected answer
  task automatic xfer(input logic rd, input logic [6:0] idx,
                      input logic [15:0] dat);
    logic [0:255] rx;
    ccs_link_ctl_model_inst.frame({16'hE000, rd, idx, 12'h000,
      rd ? 16'h0000 : dat, 4'h0, 200'h0}, rx);
    last_rx = rx;
    if (pend) begin
      chk_out({rx[0:2], rx[12], rx[17:23]}, {4'hF, pidx});
      chk_reg(rx[36:51], pexp);
    end
    pend = rd;
    pidx = idx;
    pexp = dat;
  endtask : xfer

  // same-clock status pulse, driven on the rising edge
  task automatic pulse(input int which);
    @(posedge clk_sys);
    if (which == 0) sense_done <= 1'b1;
    else if (which == 1) pin_change <= 1'b1;
    else sense_info <= 1'b1;
    @(posedge clk_sys);
    {sense_done, pin_change, sense_info} <= 3'b000;
  endtask : pulse

  // slot numbers per dac pair, one nibble per channel
  function automatic logic [23:0] smap(input logic [1:0] c);
    case (c)
      2'd0: return 24'h347869;
      2'd1: return 24'h7869AB;
      2'd2: return 24'h69AB34;
      default: return 24'hAB3478;
    endcase
  endfunction : smap

  // power controls from PR6..PR0 and the three extra dac bits
  function automatic ccs_pkg::ccs_pwr_t epwr(input logic [6:0] p,
                                            input logic [2:0] x);
    return {p[0], p[1], p[1], p[2], p[3] & p[0] & p[1], p[3], p[4],
            p[5] & p[4] & p[0] & p[1] & (&x), p[6], x[0], x[1], x[2]};
  endfunction : epwr

  initial begin
    // about 31 frames of roughly 3300 cycles each, plus margin
    repeat (106000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end

  initial begin
    void'($urandom(63));
    ready_in <= 4'($urandom);
    spdif_cfg_valid <= 1'($urandom);
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk_out(ext_amp_shutdown, 0);
    chk_out(dac_slot_map, 24'h347869);
    chk_out(ext_ctrl, 6'h10);
    // reset values through the link
    xfer(1, 7'h20, 16'h0000);
    xfer(1, 7'h26, {12'h000, ready_in});
    xfer(1, 7'h28, 16'h0BC7);
    xfer(1, 7'h2A, {5'h00, spdif_cfg_valid, 10'h1C0});
    // masked update of the general-purpose bits
    d = 16'($urandom) & 16'h0F80;
    xfer(0, 7'h20, d);
    xfer(1, 7'h20, d);
    chk_out(gp_ctrl, {d[7], d[8], d[9], d[11:10]});
    // page selection, absent page reads back differently
    xfer(0, 7'h24, 16'h0001);
    chk_out(page_selector, 4'h1);
    xfer(1, 7'h24, 16'h0001);
    xfer(0, 7'h24, {12'h000, 4'($urandom_range(15, 2))});
    xfer(1, 7'h24, 16'h0000);
    // sense cycle, cause bits and write-one-to-clear status
    xfer(0, 7'h24, 16'h1800);
    chk_out(n_st, 1);
    pulse(0);
    xfer(1, 7'h24, 16'hA800);
    chk_out(last_rx[255], 1);
    xfer(0, 7'h24, 16'h8800);
    xfer(1, 7'h24, 16'h0800);
    chk_out(last_rx[255], 0);
    pulse(1);
    xfer(0, 7'h24, 16'h0800);
    xfer(1, 7'h24, 16'hC800);
    chk_out(n_ab, 0);
    xfer(0, 7'h24, 16'h1800);
    xfer(0, 7'h24, 16'h0800);
    chk_out({n_st[3:0], n_ab[3:0]}, 8'h21);
    // polling only: masked source stays off the slot
    xfer(0, 7'h24, 16'h8000);
    pulse(2);
    // extended control with variable rate on
    d = 16'($urandom) | 16'h3801;
    xfer(0, 7'h2A, d);
    chk_out(last_rx[255], 0);
    xfer(1, 7'h2A, {2'b00, d[13:11], spdif_cfg_valid, 1'b0, ~d[13],
      ~d[12], ~d[11], d[5:4], 1'b0, d[2:0]});
    chk_out(ext_ctrl, {d[0], 1'b0, d[1], d[2], d[5:4]});
    // power-down bits, ready flags ignore writes
    d = 16'($urandom);
    xfer(0, 7'h26, d);
    chk_out(pwr_ctrl, epwr(d[14:8], 3'b111));
    chk_out(ext_amp_shutdown, d[15]);
    xfer(1, 7'h26, {d[15:8], 4'h0, ready_in});
    xfer(0, 7'h26, 16'h7F00);
    chk_out(pwr_ctrl, epwr(7'h7F, 3'b111));
    chk_out(ext_amp_shutdown, 0);
    // every slot-mapping code
    for (int c = 0; c < 4; c++) begin
      d = 16'($urandom);
      d[5:4] = 2'(c);
      xfer(0, 7'h28, d);
      chk_out(dac_slot_map, smap(2'(c)));
    end
    xfer(1, 7'h28, 16'h0BF7);
    // paged window reads zero; unmapped write is ignored
    xfer(1, 7'h62, 16'h0000);
    xfer(0, 7'h7E, 16'($urandom));
    stop_test();
  end
endmodule : tb
`default_nettype wire
